// *** hw/pec_pkg.sv ***
// shared constants and carriers for the power event and charger registers
package pec_pkg;
   // register offsets
   localparam logic [7:0] PEC_OFS_EVENT = 8'h02;
   localparam logic [7:0] PEC_OFS_CHG_STATE = 8'h03;
   localparam logic [7:0] PEC_OFS_CHG_SETUP = 8'h04;
   // event register field positions
   localparam int PEC_EV_RSVD_HI = 7;
   localparam int PEC_EV_BTN_MASK = 6;
   localparam int PEC_EV_ADP_MASK = 5;
   localparam int PEC_EV_USB_MASK = 4;
   localparam int PEC_EV_RSVD_LO = 3;
   localparam int PEC_EV_BTN_FLAG = 2;
   localparam int PEC_EV_ADP_FLAG = 1;
   localparam int PEC_EV_USB_FLAG = 0;
   // reset values, and the value read at an unmapped offset
   localparam logic PEC_EV_RSVD_HI_RST = 1'b1;
   localparam logic [2:0] PEC_EV_MASK_RST = 3'h0;
   localparam logic [7:0] PEC_CHG_STATE_RST = 8'h00;
   localparam logic [7:0] PEC_CHG_SETUP_RST = 8'hb1;
   localparam logic [7:0] PEC_UNMAPPED_READ = 8'h00;
   // fast-charge timer durations in hours per code
   localparam logic [3:0] PEC_HOURS_CODE0 = 4'h4;
   localparam logic [3:0] PEC_HOURS_CODE1 = 4'h5;
   localparam logic [3:0] PEC_HOURS_CODE2 = 4'h6;
   localparam logic [3:0] PEC_HOURS_CODE3 = 4'h8;

   // charger state, msb first as it reads in the register
   typedef struct packed {
      logic thermal_current_foldback;
      logic input_power_limit_active;
      logic battery_temp_pause;
      logic taper_current_reached;
      logic charging_active;
      logic charge_timer_expired;
      logic precharge_timer_expired;
      logic battery_thermal_fault;
   } pec_chg_state_t;

   // charger setup, msb first as it reads in the register
   typedef struct packed {
      logic [1:0] timer_sel;
      logic safety_timer_enable;
      logic thermistor_curve_select;
      logic charger_reset;
      logic termination_disable;
      logic timer_hold;
      logic charger_enable;
   } pec_chg_setup_t;

   // register access from the serial management decoder
   typedef struct packed {
      logic [7:0] addr;
      logic wr;
      logic rd;
      logic [7:0] wdata;
   } pec_reg_req_t;

   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } pec_reg_rsp_t;
endpackage

// *** hw/pec_change_flag.sv ***
// sticky change flag for one supervised level
`timescale 1ns/100ps
module pec_change_flag (
   // clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // supervised level and clear request
   input wire logic level,
   input wire logic clear,
   // sticky flag
   output logic flag
);
   logic armed_q, armed_d;
   logic prev_q, prev_d;
   logic flag_q, flag_d;
   logic toggled;

   always_comb begin
      armed_d = 1'b1;
      prev_d = level;
      // either direction counts; armed blocks a false edge after reset
      toggled = armed_q && (level != prev_q);
      // a new change beats a clear in the same cycle
      flag_d = toggled || (flag_q && !clear);
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         armed_q <= 1'b0;
         prev_q <= 1'b0;
         flag_q <= 1'b0;
      end else begin
         armed_q <= armed_d;
         prev_q <= prev_d;
         flag_q <= flag_d;
      end
   end

   assign flag = flag_q;
endmodule // pec_change_flag

// *** hw/pec_regs.sv ***
// power event, charger state and charger setup register logic
`timescale 1ns/100ps
module pec_regs
   import pec_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // register access
   input wire pec_reg_req_t reg_req,
   output pec_reg_rsp_t reg_rsp,
   // supervised levels
   input wire logic button_input,
   input wire logic adapter_present,
   input wire logic usb_present,
   // charger condition from the analog core
   input wire pec_chg_state_t chg_state_in,
   // charger control
   output pec_chg_setup_t chg_setup,
   output logic [3:0] fast_charge_hours,
   output logic charger_restart,
   // interrupt request
   output logic event_irq
);
   function automatic logic [3:0] timer_hours(input logic [1:0] code);
      case (code)
         2'h0: timer_hours = PEC_HOURS_CODE0;
         2'h1: timer_hours = PEC_HOURS_CODE1;
         2'h2: timer_hours = PEC_HOURS_CODE2;
         default: timer_hours = PEC_HOURS_CODE3;
      endcase
   endfunction

   logic ev_rsvd_q, ev_rsvd_d;
   logic [2:0] mask_q, mask_d;
   pec_chg_state_t state_q, state_d;
   pec_chg_setup_t setup_q, setup_d;
   logic [3:0] hours_q, hours_d;
   logic restart_q, restart_d;
   pec_reg_rsp_t rsp_q, rsp_d;
   logic [2:0] levels;
   logic [2:0] flags;
   logic wr_event, wr_setup, rd_event;
   logic [7:0] event_view;

   assign levels = {button_input, adapter_present, usb_present};
   assign wr_event = reg_req.wr && (reg_req.addr == PEC_OFS_EVENT);
   assign wr_setup = reg_req.wr && (reg_req.addr == PEC_OFS_CHG_SETUP);
   assign rd_event = reg_req.rd && (reg_req.addr == PEC_OFS_EVENT);

   // one flag per source, msb is the button
   for (genvar i = 0; i < 3; i++) begin : g_flag
      pec_change_flag u_flag (
         .core_clk(core_clk),
         .sys_rst(sys_rst),
         .level(levels[i]),
         .clear(rd_event),
         .flag(flags[i])
      );
   end

   always_comb begin
      event_view = 8'h00;
      event_view[PEC_EV_RSVD_HI] = ev_rsvd_q;
      event_view[PEC_EV_BTN_MASK] = mask_q[2];
      event_view[PEC_EV_ADP_MASK] = mask_q[1];
      event_view[PEC_EV_USB_MASK] = mask_q[0];
      event_view[PEC_EV_BTN_FLAG] = flags[2];
      event_view[PEC_EV_ADP_FLAG] = flags[1];
      event_view[PEC_EV_USB_FLAG] = flags[0];
   end

   // writable state
   always_comb begin
      ev_rsvd_d = ev_rsvd_q;
      mask_d = mask_q;
      setup_d = setup_q;
      if (wr_event) begin
         ev_rsvd_d = reg_req.wdata[PEC_EV_RSVD_HI];
         mask_d = {reg_req.wdata[PEC_EV_BTN_MASK],
                   reg_req.wdata[PEC_EV_ADP_MASK],
                   reg_req.wdata[PEC_EV_USB_MASK]};
      end
      if (wr_setup) begin
         setup_d = pec_chg_setup_t'(reg_req.wdata);
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         ev_rsvd_q <= PEC_EV_RSVD_HI_RST;
         mask_q <= PEC_EV_MASK_RST;
         setup_q <= pec_chg_setup_t'(PEC_CHG_SETUP_RST);
      end else begin
         ev_rsvd_q <= ev_rsvd_d;
         mask_q <= mask_d;
         setup_q <= setup_d;
      end
   end

   // charger condition snapshot and derived control
   always_comb begin
      // writes to the state offset are dropped; it only follows the core
      state_d = chg_state_in;
      hours_d = timer_hours(setup_q.timer_sel);
      // restart on the falling reset bit, after software set and cleared it
      restart_d = setup_q.charger_reset && !setup_d.charger_reset;
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         state_q <= pec_chg_state_t'(PEC_CHG_STATE_RST);
         hours_q <= 4'h0;
         restart_q <= 1'b0;
      end else begin
         state_q <= state_d;
         hours_q <= hours_d;
         restart_q <= restart_d;
      end
   end

   // read path, answer one cycle after the strobe
   always_comb begin
      rsp_d.valid = reg_req.rd;
      rsp_d.data = rsp_q.data;
      if (reg_req.rd) begin
         case (reg_req.addr)
            PEC_OFS_EVENT: rsp_d.data = event_view;
            PEC_OFS_CHG_STATE: rsp_d.data = 8'(state_q);
            PEC_OFS_CHG_SETUP: rsp_d.data = 8'(setup_q);
            default: rsp_d.data = PEC_UNMAPPED_READ;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         rsp_q <= '0;
      end else begin
         rsp_q <= rsp_d;
      end
   end

   assign reg_rsp = rsp_q;
   assign chg_setup = setup_q;
   assign fast_charge_hours = hours_q;
   assign charger_restart = restart_q;
   assign event_irq = |(flags & ~mask_q);

   // checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   AST_BTN_TOGGLE: assert property (
      !$past(sys_rst) && $changed(button_input) |=> flags[2])
      else $error("button toggle did not raise its flag");

   AST_ADP_TOGGLE: assert property (
      !$past(sys_rst) && $changed(adapter_present) |=> flags[1])
      else $error("adapter change did not raise its flag");

   AST_USB_TOGGLE: assert property (
      !$past(sys_rst) && $changed(usb_present) |=> flags[0])
      else $error("usb change did not raise its flag");

   AST_BTN_MASKED: assert property (
      mask_q[2] && !(flags[1] && !mask_q[1]) && !(flags[0] && !mask_q[0])
      |-> !event_irq)
      else $error("masked button change raised the interrupt");

   AST_ADP_UNMASKED: assert property (
      flags[1] && !mask_q[1] |-> event_irq)
      else $error("unmasked adapter change gave no interrupt");

   AST_USB_MASK_WRITE: assert property (
      wr_event && reg_req.wdata[PEC_EV_USB_MASK] && !flags[2] && !flags[1]
      && $stable(levels) |=> !event_irq)
      else $error("usb mask write did not block the interrupt");

   AST_READ_CLEARS: assert property (
      rd_event && $stable(levels) |=> flags == 3'h0)
      else $error("event read did not clear the flags");

   AST_EVENT_READ: assert property (
      rd_event |=> reg_rsp.valid && !reg_rsp.data[PEC_EV_RSVD_LO]
      && reg_rsp.data[PEC_EV_RSVD_HI] == $past(ev_rsvd_q))
      else $error("event register read back wrong");

   AST_STATE_READ: assert property (
      reg_req.rd && reg_req.addr == PEC_OFS_CHG_STATE
      |=> reg_rsp.data == 8'($past(chg_state_in, 2)))
      else $error("charger state read does not follow the core");

   AST_SETUP_RESET: assert property (
      $past(sys_rst) |-> 8'(setup_q) == PEC_CHG_SETUP_RST)
      else $error("charger setup reset value wrong");

   AST_HOURS: assert property (
      wr_setup ##1 !wr_setup |=> fast_charge_hours ==
      timer_hours($past(reg_req.wdata[7:6], 2)))
      else $error("fast charge hours do not match the timer code");

   AST_CHG_DISABLE: assert property (
      wr_setup && !reg_req.wdata[0] |=> !chg_setup.charger_enable)
      else $error("charger enable did not clear");

   AST_RESTART: assert property (
      $fell(setup_q.charger_reset) |-> charger_restart ##1 !charger_restart)
      else $error("charger restart pulse missing or too long");

   AST_BTN_UNMASKED: assert property (
      flags[2] && !mask_q[2] |-> event_irq)
      else $error("unmasked button change gave no interrupt");

   AST_ADP_MASKED: assert property (
      mask_q[1] && !(flags[2] && !mask_q[2]) && !(flags[0] && !mask_q[0])
      |-> !event_irq)
      else $error("masked adapter change raised the interrupt");

   AST_USB_UNMASKED: assert property (
      flags[0] && !mask_q[0] |-> event_irq)
      else $error("unmasked usb change gave no interrupt");

   AST_MASK_WRITE: assert property (
      wr_event |=> mask_q[0] == $past(reg_req.wdata[PEC_EV_USB_MASK]))
      else $error("usb mask did not take the written value");

   AST_QUIET_NO_FLAG: assert property (
      $stable(levels) && flags == 3'h0 |=> flags == 3'h0)
      else $error("a flag set with no level change");

   AST_FLAG_STICKY: assert property (
      !rd_event |=> ($past(flags) & ~flags) == 3'h0)
      else $error("a flag cleared without an event read");

   AST_EVENT_RESET: assert property (
      $past(sys_rst) |-> ev_rsvd_q == PEC_EV_RSVD_HI_RST
      && mask_q == PEC_EV_MASK_RST && flags == 3'h0)
      else $error("event register reset value wrong");

   AST_NO_FALSE_EDGE: assert property (
      $past(sys_rst) |=> flags == 3'h0)
      else $error("a flag set by the release of reset");

   AST_STATE_RESET: assert property (
      $past(sys_rst) |-> 8'(state_q) == PEC_CHG_STATE_RST)
      else $error("charger state reset value wrong");

   AST_STATE_WRITE: assert property (
      reg_req.wr && reg_req.addr == PEC_OFS_CHG_STATE
      |=> state_q == $past(chg_state_in))
      else $error("write to the charger state took effect");

   AST_SETUP_WRITE: assert property (
      wr_setup |=> 8'(setup_q) == $past(reg_req.wdata))
      else $error("charger setup did not take the written value");

   AST_SETUP_READ: assert property (
      reg_req.rd && reg_req.addr == PEC_OFS_CHG_SETUP
      |=> reg_rsp.data == 8'($past(setup_q)))
      else $error("charger setup read back wrong");

   AST_CHG_ENABLE: assert property (
      wr_setup && reg_req.wdata[0] |=> chg_setup.charger_enable)
      else $error("charger enable did not set");

   AST_RESTART_CAUSE: assert property (
      charger_restart |-> $past(setup_q.charger_reset)
      && !setup_q.charger_reset)
      else $error("restart pulse without a falling reset bit");

   COV_BTN_IRQ: cover property (flags[2] && event_irq);
   COV_SET_BEATS_CLEAR: cover property (rd_event && $changed(levels));
   COV_MID_RESET: cover property ($past(sys_rst) && levels != 3'h0);
   COV_READ_CLEAR: cover property (rd_event && flags != 3'h0);
   COV_RESTART: cover property (charger_restart);
endmodule // pec_regs

// *** test/pec_host_model.sv ***
// host model that issues register reads and writes
`timescale 1ns/100ps
module pec_host_model
   import pec_pkg::*;
(
   // clock
   input wire logic core_clk,
   // register access
   output pec_reg_req_t reg_req,
   input wire pec_reg_rsp_t reg_rsp
);
   initial reg_req = '0;

   // one-cycle write strobe, then fields moved off the written values
   task automatic write(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
      @(posedge core_clk);
      reg_req <= '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~d};
   endtask

   // answer is taken at the edge after the strobe is accepted
   task automatic read(input logic [7:0] a, output logic [7:0] d);
      @(posedge core_clk);
      reg_req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
      @(posedge core_clk);
      reg_req <= '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: 8'hff};
      @(posedge core_clk);
      d = (reg_rsp.valid === 1'b1) ? reg_rsp.data : 8'hxx;
   endtask
endmodule // pec_host_model

// *** test/tb_pec_regs.sv ***
// self-checking bench for the power event and charger registers
`timescale 1ns/100ps
module tb_pec_regs
   import pec_pkg::*;
   ;
   localparam logic [3:0] HRS [4] = '{4'h4, 4'h5, 4'h6, 4'h8};
   logic core_clk = 1'b0;
   logic sys_rst = 1'b1;
   pec_reg_req_t reg_req;
   pec_reg_rsp_t reg_rsp;
   logic [2:0] lvl = 3'h0;
   pec_chg_state_t chg_state_in = '0;
   pec_chg_setup_t chg_setup;
   logic [3:0] fast_charge_hours;
   logic charger_restart;
   logic event_irq;
   int fail_count = 0;
   int checks = 0;

   always #5 core_clk = ~core_clk;

   pec_regs uut (
      .core_clk(core_clk), .sys_rst(sys_rst),
      .reg_req(reg_req), .reg_rsp(reg_rsp),
      .button_input(lvl[2]), .adapter_present(lvl[1]),
      .usb_present(lvl[0]), .chg_state_in(chg_state_in),
      .chg_setup(chg_setup), .fast_charge_hours(fast_charge_hours),
      .charger_restart(charger_restart), .event_irq(event_irq)
   );

   pec_host_model host (
      .core_clk(core_clk), .reg_req(reg_req), .reg_rsp(reg_rsp)
   );

   task automatic chk8(input string what, input logic [7:0] exp,
      input logic [7:0] got);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic chk1(input string what, input logic exp, input logic got);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR %s expected %b seen %b", what, exp, got);
      end
   endtask

   task automatic rdchk(input string what, input logic [7:0] a,
      input logic [7:0] exp);
      logic [7:0] d;
      host.read(a, d);
      chk8(what, exp, d);
   endtask

   // flip one supervised level, then settle past the detecting edge
   task automatic toggle(input int i);
      @(posedge core_clk);
      lvl[i] <= ~lvl[i];
      @(posedge core_clk);
      #1;
   endtask

   task automatic t_reset();
      rdchk("event reset", PEC_OFS_EVENT, 8'h80);
      rdchk("state reset", PEC_OFS_CHG_STATE, 8'h00);
      rdchk("setup reset", PEC_OFS_CHG_SETUP, 8'hb1);
      chk8("setup port", 8'hb1, chg_setup);
      rdchk("unmapped", 8'h07, 8'h00);
      chk1("irq idle", 1'b0, event_irq);
      $display("t_reset done");
   endtask

   // drive one charger condition bit alone and read it back
   task automatic state_bit(input int i);
      @(posedge core_clk);
      chg_state_in <= pec_chg_state_t'(8'h01 << i);
      rdchk("state bit", PEC_OFS_CHG_STATE, 8'h01 << i);
   endtask

   task automatic t_state();
      state_bit(7);
      state_bit(6);
      state_bit(5);
      state_bit(4);
      state_bit(3);
      state_bit(2);
      state_bit(1);
      state_bit(0);
      @(posedge core_clk);
      chg_state_in <= pec_chg_state_t'(8'hc8);
      host.write(PEC_OFS_CHG_STATE, 8'h00);
      rdchk("state read only", PEC_OFS_CHG_STATE, 8'hc8);
      $display("t_state done");
   endtask

   task automatic t_setup();
      logic [7:0] wd;
      for (int c = 0; c < 4; c++) begin
         wd = {c[1:0], 5'h18, c[0]};
         host.write(PEC_OFS_CHG_SETUP, wd);
         #1;
         chk8("setup port", wd, chg_setup);
         chk1("enable", c[0], chg_setup.charger_enable);
         @(posedge core_clk);
         #1;
         chk8("hours", 8'(HRS[c]), 8'(fast_charge_hours));
         rdchk("setup readback", PEC_OFS_CHG_SETUP, wd);
      end
      $display("t_setup done");
   endtask

   task automatic t_restart();
      host.write(PEC_OFS_CHG_SETUP, 8'hb9);
      #1;
      chk1("no restart on set", 1'b0, charger_restart);
      host.write(PEC_OFS_CHG_SETUP, 8'hb1);
      #1;
      chk1("restart pulse", 1'b1, charger_restart);
      @(posedge core_clk);
      #1;
      chk1("restart one cycle", 1'b0, charger_restart);
      $display("t_restart done");
   endtask

   // one source: unmasked change, clear by read, then masked change
   task automatic event_source(input int i);
      logic [7:0] m;
      logic [7:0] f;
      m = 8'h10 << i;
      f = 8'h01 << i;
      toggle(i);
      chk1("irq unmasked", 1'b1, event_irq);
      rdchk("flag set", PEC_OFS_EVENT, 8'h80 | f);
      rdchk("flag cleared", PEC_OFS_EVENT, 8'h80);
      chk1("irq cleared", 1'b0, event_irq);
      host.write(PEC_OFS_EVENT, 8'h80 | m);
      toggle(i);
      chk1("irq masked", 1'b0, event_irq);
      rdchk("masked flag", PEC_OFS_EVENT, 8'h80 | m | f);
      host.write(PEC_OFS_EVENT, 8'h80);
   endtask

   task automatic t_events();
      host.write(PEC_OFS_EVENT, 8'hff);
      rdchk("event writable", PEC_OFS_EVENT, 8'hf0);
      host.write(PEC_OFS_EVENT, 8'h80);
      event_source(2);
      event_source(1);
      event_source(0);
      $display("t_events done");
   endtask

   // a change in the very cycle of an event read must survive the clear
   task automatic t_collide();
      fork
         rdchk("read at toggle", PEC_OFS_EVENT, 8'h80);
         toggle(2);
      join
      #1;
      chk1("irq after collide", 1'b1, event_irq);
      rdchk("set beats clear", PEC_OFS_EVENT, 8'h84);
      $display("t_collide done");
   endtask

   // reset in mid-run with a level held high and registers off reset
   task automatic t_midreset();
      host.write(PEC_OFS_CHG_SETUP, 8'h78);
      host.write(PEC_OFS_EVENT, 8'h70);
      rdchk("reserved cleared", PEC_OFS_EVENT, 8'h70);
      @(posedge core_clk);
      sys_rst <= 1'b1;
      repeat (2) @(posedge core_clk);
      sys_rst <= 1'b0;
      rdchk("event after reset", PEC_OFS_EVENT, 8'h80);
      rdchk("setup after reset", PEC_OFS_CHG_SETUP, 8'hb1);
      chk8("hours reset", 8'h06, 8'(fast_charge_hours));
      chk1("irq after reset", 1'b0, event_irq);
      $display("t_midreset done");
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   initial begin
      repeat (2) @(posedge core_clk);
      sys_rst <= 1'b0;
      t_reset();
      t_state();
      t_setup();
      t_restart();
      t_events();
      t_collide();
      t_midreset();
      print_verdict();
   end

   // the tests need under two hundred cycles
   initial begin
      repeat (3000) @(posedge core_clk);
      fail_count++;
      print_verdict();
   end
endmodule // tb_pec_regs
